// file: rtl/addr_buf_ctrl_pkg.sv
package addr_buf_ctrl_pkg;
   localparam int CPU_ADDR_W = 16;
   localparam int SLOT_ADDR_W = 17;
   localparam int DRAM_ADDR_W = 8;
   localparam int REFRESH_W = 9;
   localparam int CLK_PERIOD_NS = 5;
   // Least time each strobe phase holds, and its cycle count (rounded up)
   localparam int STROBE_NS = 20;
   localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(STROBE_CYC - 1);
   typedef enum logic [3:0] {
      ST_IDLE, ST_MEM_OPEN, ST_ALE_HIGH, ST_HOLD_ADDR, ST_ROW, ST_COL, ST_END,
      ST_REF_EN, ST_REF_STB, ST_REF_DONE
   } ctrl_state_t;
endpackage

// file: rtl/sync_2ff.sv
`timescale 1ns/100ps
`default_nettype none
module sync_2ff #(
   parameter int WIDTH = 1
) (
   input wire logic core_clk_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_r;
   always_ff @(posedge core_clk_i) begin
      meta_r <= d_i;
      q_o <= meta_r;
   end
endmodule
`default_nettype wire

// file: rtl/address_buffer_refresh_ctrl.sv
// Summary of operation
// - Controller raises early latch enable at the end of every bus cycle.
// - Controller drops early latch enable at end of status phase.
// - No address strobe pulse during a halt bus cycle.
// - Hold acknowledge high while processor bus floated and during every refresh cycle, low otherwise.
// - DMA address enable held low for the whole DMA access.
// - Refresh strobe low starts refresh and clocks the refresh counter.
// - Refresh enable driven low whenever a refresh cycle is needed.
// - Synchronised active-high system reset clears the refresh counter.
// - Upper byte enable driven low when transfer uses upper data byte.
`timescale 1ns/100ps
`default_nettype none
module address_buffer_refresh_ctrl (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic cycle_req_i,
   input wire logic [addr_buf_ctrl_pkg::CPU_ADDR_W-1:0] cycle_addr_i,
   input wire logic cycle_upper_i,
   input wire logic cycle_halt_i,
   input wire logic refresh_req_i,
   input wire logic dma_active_i,
   input wire logic hold_ack_req_i,
   input wire logic [addr_buf_ctrl_pkg::DRAM_ADDR_W-1:0] dram_addr_in_i,
   input wire logic refresh_count_msb_in_i,
   output logic busy_o,
   output logic done_o,
   output logic [addr_buf_ctrl_pkg::DRAM_ADDR_W-1:0] row_addr_o,
   output logic [addr_buf_ctrl_pkg::DRAM_ADDR_W-1:0] col_addr_o,
   output logic refresh_msb_o,
   output logic [addr_buf_ctrl_pkg::CPU_ADDR_W-1:0] cpu_addr_in_o,
   output logic upper_byte_enable_n_o,
   output logic early_mem_latch_enable_o,
   output logic addr_latch_strobe_o,
   output logic hold_ack_in_o,
   output logic dma_addr_enable_n_o,
   output logic refresh_strobe_n_o,
   output logic refresh_enable_n_o,
   output logic row_col_select_o,
   output logic system_reset_o,
   output logic test_float_n_o
);
   addr_buf_ctrl_pkg::ctrl_state_t state_r;
   logic [addr_buf_ctrl_pkg::CNT_W-1:0] cnt_r;
   logic [addr_buf_ctrl_pkg::DRAM_ADDR_W-1:0] dram_sync;
   logic msb_sync;
   logic req_sync, hold_sync, dma_sync, rrq_sync;
   logic [addr_buf_ctrl_pkg::CPU_ADDR_W-1:0] addr_sync;
   logic upper_sync, halt_sync;
   logic step;

   // Pins from the device and asynchronous request levels pass two flops
   sync_2ff #(.WIDTH(addr_buf_ctrl_pkg::DRAM_ADDR_W + 1)) u_sync_dram (
      .core_clk_i(core_clk_i),
      .d_i({refresh_count_msb_in_i, dram_addr_in_i}),
      .q_o({msb_sync, dram_sync})
   );
   sync_2ff #(.WIDTH(4)) u_sync_ctl (
      .core_clk_i(core_clk_i),
      .d_i({cycle_req_i, hold_ack_req_i, dma_active_i, refresh_req_i}),
      .q_o({req_sync, hold_sync, dma_sync, rrq_sync})
   );
   sync_2ff #(.WIDTH(addr_buf_ctrl_pkg::CPU_ADDR_W + 2)) u_sync_cyc (
      .core_clk_i(core_clk_i),
      .d_i({cycle_halt_i, cycle_upper_i, cycle_addr_i}),
      .q_o({halt_sync, upper_sync, addr_sync})
   );

   assign step = (cnt_r == addr_buf_ctrl_pkg::STROBE_LAST);
   assign busy_o = (state_r != addr_buf_ctrl_pkg::ST_IDLE);

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i || state_r == addr_buf_ctrl_pkg::ST_IDLE || step) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         state_r <= addr_buf_ctrl_pkg::ST_IDLE;
      end else begin
         case (state_r)
            addr_buf_ctrl_pkg::ST_IDLE: begin
               if (rrq_sync) begin
                  state_r <= addr_buf_ctrl_pkg::ST_REF_EN;
               end else if (req_sync && !hold_sync) begin
                  state_r <= addr_buf_ctrl_pkg::ST_MEM_OPEN;
               end
            end
            addr_buf_ctrl_pkg::ST_MEM_OPEN: begin
               if (step) state_r <= addr_buf_ctrl_pkg::ST_ALE_HIGH;
            end
            addr_buf_ctrl_pkg::ST_ALE_HIGH: begin
               if (step) state_r <= addr_buf_ctrl_pkg::ST_HOLD_ADDR;
            end
            addr_buf_ctrl_pkg::ST_HOLD_ADDR: begin
               if (step) state_r <= addr_buf_ctrl_pkg::ST_ROW;
            end
            addr_buf_ctrl_pkg::ST_ROW: begin
               if (step) state_r <= addr_buf_ctrl_pkg::ST_COL;
            end
            addr_buf_ctrl_pkg::ST_COL: begin
               if (step) state_r <= addr_buf_ctrl_pkg::ST_END;
            end
            addr_buf_ctrl_pkg::ST_END: begin
               if (step) state_r <= addr_buf_ctrl_pkg::ST_IDLE;
            end
            addr_buf_ctrl_pkg::ST_REF_EN: begin
               if (step) state_r <= addr_buf_ctrl_pkg::ST_REF_STB;
            end
            addr_buf_ctrl_pkg::ST_REF_STB: begin
               if (step) state_r <= addr_buf_ctrl_pkg::ST_REF_DONE;
            end
            addr_buf_ctrl_pkg::ST_REF_DONE: begin
               if (step) state_r <= addr_buf_ctrl_pkg::ST_IDLE;
            end
            default: state_r <= addr_buf_ctrl_pkg::ST_IDLE;
         endcase
      end
   end

   // Processor-side address and byte enable, captured when a cycle starts
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         cpu_addr_in_o <= '0;
         upper_byte_enable_n_o <= 1'b1;
      end else if (state_r == addr_buf_ctrl_pkg::ST_IDLE && req_sync && !rrq_sync && !hold_sync) begin
         cpu_addr_in_o <= addr_sync;
         upper_byte_enable_n_o <= !upper_sync;
      end
   end

   // Early latch stays open between cycles, closes after the status phase
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         early_mem_latch_enable_o <= 1'b1;
      end else if (state_r == addr_buf_ctrl_pkg::ST_ALE_HIGH && step) begin
         early_mem_latch_enable_o <= 1'b0;
      end else if (state_r == addr_buf_ctrl_pkg::ST_END && step) begin
         early_mem_latch_enable_o <= 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         addr_latch_strobe_o <= 1'b0;
      end else begin
         addr_latch_strobe_o <= (state_r == addr_buf_ctrl_pkg::ST_MEM_OPEN) && step && !halt_sync;
         if (state_r == addr_buf_ctrl_pkg::ST_ALE_HIGH && step) begin
            addr_latch_strobe_o <= 1'b0;
         end else if (state_r == addr_buf_ctrl_pkg::ST_ALE_HIGH) begin
            addr_latch_strobe_o <= addr_latch_strobe_o;
         end
      end
   end

   // Row/column select for the multiplexed DRAM address
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         row_col_select_o <= 1'b0;
      end else begin
         row_col_select_o <= (state_r == addr_buf_ctrl_pkg::ST_ROW && step) ||
                             (state_r == addr_buf_ctrl_pkg::ST_COL && !step);
      end
   end

   // Sample the DRAM bus halves as the device presents them
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         row_addr_o <= '0;
         col_addr_o <= '0;
         refresh_msb_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (state_r == addr_buf_ctrl_pkg::ST_ROW && step) begin
            row_addr_o <= dram_sync;
         end
         // High half has crossed the synchroniser by the last select-high cycle
         if (state_r == addr_buf_ctrl_pkg::ST_COL && step) begin
            col_addr_o <= dram_sync;
         end
         if (state_r == addr_buf_ctrl_pkg::ST_END && step) begin
            done_o <= 1'b1;
         end
         if (state_r == addr_buf_ctrl_pkg::ST_REF_DONE && step) begin
            row_addr_o <= dram_sync;
            refresh_msb_o <= msb_sync;
            done_o <= 1'b1;
         end
      end
   end

   // Hold, DMA and refresh controls
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         hold_ack_in_o <= 1'b0;
         dma_addr_enable_n_o <= 1'b1;
         refresh_enable_n_o <= 1'b1;
         refresh_strobe_n_o <= 1'b1;
      end else begin
         hold_ack_in_o <= hold_sync || (state_r inside {addr_buf_ctrl_pkg::ST_REF_EN,
            addr_buf_ctrl_pkg::ST_REF_STB, addr_buf_ctrl_pkg::ST_REF_DONE});
         dma_addr_enable_n_o <= !(hold_sync && dma_sync);
         refresh_enable_n_o <= !(state_r inside {addr_buf_ctrl_pkg::ST_REF_EN,
            addr_buf_ctrl_pkg::ST_REF_STB, addr_buf_ctrl_pkg::ST_REF_DONE});
         refresh_strobe_n_o <= !(state_r == addr_buf_ctrl_pkg::ST_REF_STB ||
            state_r == addr_buf_ctrl_pkg::ST_REF_DONE && !step);
      end
   end

   // Device reset mirrors core reset, already on this clock
   always_ff @(posedge core_clk_i) begin
      system_reset_o <= !resetn_i;
      test_float_n_o <= 1'b1;
   end
endmodule
`default_nettype wire

// file: verification/abr_chk.sv
`timescale 1ns/100ps
`default_nettype none
module abr_chk (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic cycle_upper_i,
   input wire logic cycle_halt_i,
   input wire logic dma_active_i,
   input wire logic done_o,
   input wire logic upper_byte_enable_n_o,
   input wire logic early_mem_latch_enable_o,
   input wire logic addr_latch_strobe_o,
   input wire logic hold_ack_in_o,
   input wire logic dma_addr_enable_n_o,
   input wire logic refresh_strobe_n_o,
   input wire logic refresh_enable_n_o,
   input wire logic test_float_n_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   a_halt_no_strobe: assert property (cycle_halt_i |-> !$rose(addr_latch_strobe_o)) else $error("strobe in halt");
   a_end_latch_open: assert property (done_o |-> early_mem_latch_enable_o) else $error("latch shut at end");
   a_status_latch_shut: assert property ($rose(addr_latch_strobe_o) |-> ##[1:8] !early_mem_latch_enable_o)
      else $error("latch not shut");
   a_refresh_in_hold: assert property (!refresh_strobe_n_o |-> hold_ack_in_o && !refresh_enable_n_o)
      else $error("refresh outside hold");
   a_dma_enable_low: assert property ($rose(dma_active_i) |-> ##[1:6] !dma_addr_enable_n_o)
      else $error("dma enable late");
   a_strobe_then_done: assert property ($rose(refresh_strobe_n_o) |-> done_o)
      else $error("refresh not done");
   a_upper_byte_set: assert property ($rose(addr_latch_strobe_o) |-> upper_byte_enable_n_o == !cycle_upper_i)
      else $error("upper byte wrong");
   a_float_off: assert property (test_float_n_o) else $error("outputs floated");
endmodule
bind address_buffer_refresh_ctrl abr_chk u_chk (.*);
`default_nettype wire

// file: verification/abr_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
module abr_dev_model (
   input wire logic [15:0] addr_i,
   input wire logic early_i,
   input wire logic hold_i,
   input wire logic stb_n_i,
   input wire logic en_n_i,
   input wire logic sel_i,
   input wire logic rst_i,
   input wire logic float_n_i,
   input wire logic ale_i,
   output logic [7:0] ma_o,
   output logic msb_o,
   output logic [15:0] slot_o,
   output logic sa0_drv_o
);
   logic [15:0] slot_r;
   logic [15:0] mem_r;
   logic [8:0] cnt_r;
   logic [8:0] held_r;
   logic [7:0] ma;
   always_latch if (early_i) mem_r <= addr_i;
   always_latch if (ale_i) slot_r <= addr_i;
   assign slot_o = slot_r;
   assign sa0_drv_o = float_n_i && hold_i && !en_n_i;
   always @(posedge stb_n_i or posedge rst_i) cnt_r <= rst_i ? 9'h000 : cnt_r + 9'h001;
   always @(negedge en_n_i or posedge rst_i) held_r <= rst_i ? 9'h000 : cnt_r;
   always_comb begin
      if (!hold_i) ma = sel_i ? mem_r[15:8] : mem_r[7:0];
      else if (!en_n_i || !stb_n_i) ma = sel_i ? 8'h00 : {held_r[0], held_r[7:1]};
      else ma = ~mem_r[7:0];
   end
   assign ma_o = float_n_i ? ma : 8'hzz;
   assign msb_o = cnt_r[8];
endmodule
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic core_clk_i = 1'b0, resetn_i = 1'b0, cycle_req_i = 1'b0, cycle_upper_i = 1'b0, cycle_halt_i = 1'b0;
   logic refresh_req_i = 1'b0, dma_active_i = 1'b0, hold_ack_req_i = 1'b0, refresh_count_msb_in_i;
   logic [15:0] cycle_addr_i = 16'h0000, cpu_addr_in_o;
   logic [7:0] dram_addr_in_i, row_addr_o, col_addr_o;
   logic busy_o, done_o, refresh_msb_o, upper_byte_enable_n_o, early_mem_latch_enable_o, addr_latch_strobe_o;
   logic hold_ack_in_o, dma_addr_enable_n_o, refresh_strobe_n_o, refresh_enable_n_o, row_col_select_o;
   logic system_reset_o, test_float_n_o;
   logic [15:0] slot_addr;
   logic sa0_drv;
   int fails = 0, checks_done = 0, cyc = 0, nals = 0;
   bit ok;
   address_buffer_refresh_ctrl dut (.*);
   abr_dev_model u_dev (.addr_i(cpu_addr_in_o), .early_i(early_mem_latch_enable_o), .hold_i(hold_ack_in_o),
      .stb_n_i(refresh_strobe_n_o), .en_n_i(refresh_enable_n_o), .sel_i(row_col_select_o), .rst_i(system_reset_o),
      .float_n_i(test_float_n_o), .ale_i(addr_latch_strobe_o), .ma_o(dram_addr_in_i), .msb_o(refresh_count_msb_in_i),
      .slot_o(slot_addr), .sa0_drv_o(sa0_drv));
   always #2.5 core_clk_i = ~core_clk_i;
   always @(posedge addr_latch_strobe_o) nals++;
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 9000) begin
         fails++;
         finish_test();
      end
   end
   task automatic check(input logic [15:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("fails=%0d checks_done=%0d", fails, checks_done);
      if (fails == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic kick(ref logic r);
      r = 1'b1;
      for (int i = 0; i < 12 && busy_o !== 1'b1; i++) @(negedge core_clk_i);
      r = 1'b0;
      ok = 1'b0;
      for (int i = 0; i < 60 && !ok; i++) begin
         @(negedge core_clk_i);
         ok = (done_o === 1'b1);
      end
      check(ok, 1'b1);
   endtask
   task automatic bus_cycle(input logic [15:0] a, input logic up, halt);
      int n0;
      logic [15:0] s0;
      n0 = nals;
      s0 = slot_addr;
      cycle_addr_i = a;
      cycle_upper_i = up;
      cycle_halt_i = halt;
      kick(cycle_req_i);
      check(row_addr_o, a[7:0]);
      check(col_addr_o, a[15:8]);
      check(cpu_addr_in_o, a);
      check(16'(nals - n0), halt ? 16'h0000 : 16'h0001);
      check(slot_addr, halt ? s0 : a);
      check(sa0_drv, 1'b0);
      cycle_halt_i = 1'b0;
   endtask
   task automatic refresh(input int n);
      logic [8:0] q;
      q = n[8:0];
      kick(refresh_req_i);
      check(row_addr_o, {q[0], q[7:1]});
      check(sa0_drv, 1'b1);
      check(refresh_msb_o, 16'(n >> 8));
   endtask
   task automatic hold_dma();
      hold_ack_req_i = 1'b1;
      dma_active_i = 1'b1;
      cycle_req_i = 1'b1;
      repeat (40) @(negedge core_clk_i);
      check(busy_o, 1'b0);
      check(hold_ack_in_o, 1'b1);
      check(dma_addr_enable_n_o, 1'b0);
      hold_ack_req_i = 1'b0;
      dma_active_i = 1'b0;
      bus_cycle(16'h1234, 1'b0, 1'b0);
      check(dma_addr_enable_n_o, 1'b1);
   endtask
   initial begin
      repeat (12) @(negedge core_clk_i);
      check(system_reset_o, 1'b1);
      resetn_i = 1'b1;
      bus_cycle(16'ha5c3, 1'b1, 1'b0);
      bus_cycle(16'h5a3c, 1'b0, 1'b0);
      bus_cycle(16'hffff, 1'b1, 1'b1);
      hold_dma();
      for (int i = 0; i < 258; i++) refresh(i);
      resetn_i = 1'b0;
      repeat (3) @(negedge core_clk_i);
      resetn_i = 1'b1;
      refresh(0);
      finish_test();
   end
endmodule
`default_nettype wire
